//--- cgr_pkg.sv
// constants for the clock generator control register bank
`default_nettype none
package cgr_pkg;
    // register indices (byte offsets on the serial link)
    localparam logic [7:0] IDX_USB_EN   = 8'h02;
    localparam logic [7:0] IDX_LINK_EN  = 8'h03;
    localparam logic [7:0] IDX_HOST_EN  = 8'h04;
    localparam logic [7:0] IDX_RSVD5    = 8'h05;
    localparam logic [7:0] IDX_SWING_A  = 8'h06;
    localparam logic [7:0] IDX_REV      = 8'h07;
    localparam logic [7:0] IDX_BLK_LEN  = 8'h08;
    localparam logic [7:0] IDX_WD_CTRL  = 8'h09;
    localparam logic [7:0] IDX_SWING_B  = 8'h0a;
    localparam logic [7:0] IDX_RSVD11   = 8'h0b;
    localparam logic [7:0] IDX_VCO_DIV  = 8'h0c;
    localparam int         NUM_REGS     = 13;
    // power-up values
    localparam logic [7:0] RST_USB_EN   = 8'hf8;
    localparam logic [7:0] RST_LINK_EN  = 8'hf3;
    localparam logic [7:0] RST_HOST_EN  = 8'hf4;
    localparam logic [7:0] RST_SWING_A  = 8'h8a;
    localparam logic [7:0] RST_BLK_LEN  = 8'h0f;
    localparam logic [7:0] RST_WD_CTRL  = 8'h1e;
    localparam logic [7:0] RST_SWING_B  = 8'ha0;
    // writable bit masks
    localparam logic [7:0] WMASK_FULL   = 8'hff;
    localparam logic [7:0] WMASK_BLKLEN = 8'h1f;
    localparam logic [7:0] WMASK_WD     = 8'hbf;
    // field positions
    localparam int BIT_USB_EN    = 7;
    localparam int BIT_EXP_EN    = 5;
    localparam int BIT_STOR_EN   = 1;
    localparam int BIT_REF_EN    = 6;
    localparam int BIT_CPU_EN    = 4;
    localparam int BIT_WD_EN     = 7;
    localparam int BIT_WD_FLAG   = 6;
    localparam int BIT_WD_TB     = 5;
    localparam int POS_WD_CNT    = 1;
    localparam int POS_SWING_HI  = 6;
    localparam int POS_SWING_LO  = 2;
    localparam int POS_SWING_STG = 4;
    // serial link addresses and idle transmit byte
    localparam logic [7:0] ADDR_WR      = 8'hd2;
    localparam logic [7:0] ADDR_RD      = 8'hd3;
    localparam logic [7:0] TX_IDLE      = 8'hff;
    // watchdog timebase
    localparam int unsigned REF_CLK_KHZ   = 100000;
    localparam int unsigned WD_SHORT_MS   = 290;
    localparam int unsigned WD_LONG_MS    = 1160;
    localparam int unsigned WD_SHORT_CYC  = WD_SHORT_MS * REF_CLK_KHZ;
    localparam int unsigned WD_LONG_CYC   = WD_LONG_MS * REF_CLK_KHZ;
    localparam int          WD_UNIT_W     = 27;
    localparam logic [3:0]  RST_WD_CNT    = 4'hf;
endpackage
`default_nettype wire

//--- cgr_regs.sv
// control and status register bank with link byte sequencer and watchdog
`timescale 1ns/1ps
`default_nettype none
module cgr_regs #(
    parameter int unsigned WD_SHORT_CYC = cgr_pkg::WD_SHORT_CYC,
    parameter int unsigned WD_LONG_CYC  = cgr_pkg::WD_LONG_CYC,
    parameter logic [3:0]  REV_CODE     = 4'h0,  // arbitrary value
    parameter logic [3:0]  MAKER_CODE   = 4'h5   // arbitrary value
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       link_clk_i,
    input  wire logic       lk_start_i,
    input  wire logic       lk_stop_i,
    input  wire logic       lk_rx_valid_i,
    input  wire logic [7:0] lk_rx_byte_i,
    output logic            lk_ack_o,
    input  wire logic       lk_tx_req_i,
    output logic      [7:0] lk_tx_byte_o,
    input  wire logic [7:0] vco_strap_i,
    output logic            usb_clock_out_en_o,
    output logic            ref_clock_out_en_o,
    output logic            expansion_clock_pair_en_o,
    output logic            storage_link_clock_pair_en_o,
    output logic            processor_clock_pair_en_o,
    output logic      [1:0] processor_swing_select_o,
    output logic      [1:0] display_96mhz_swing_select_o,
    output logic      [1:0] expansion_swing_select_o,
    output logic      [1:0] storage_link_swing_select_o,
    output logic      [7:0] vco_feedback_divider_o,
    output logic            hard_alarm_flag_o
);
    typedef enum logic [2:0] {
        CGR_IDLE   = 3'b000,
        CGR_ADDR   = 3'b001,
        CGR_INDEX  = 3'b010,
        CGR_COUNT  = 3'b011,
        CGR_WDATA  = 3'b100,
        CGR_RDATA  = 3'b101,
        CGR_IGNORE = 3'b110
    } cgr_lk_state_t;

    // maker code is arbitrary; revision code is arbitrary
    localparam logic [7:0] REV_MAKER = {REV_CODE, MAKER_CODE};

    function automatic logic [7:0] wr_mask(input logic [7:0] idx);
        case (idx)
            cgr_pkg::IDX_USB_EN,
            cgr_pkg::IDX_LINK_EN,
            cgr_pkg::IDX_HOST_EN,
            cgr_pkg::IDX_SWING_A,
            cgr_pkg::IDX_SWING_B,
            cgr_pkg::IDX_VCO_DIV: wr_mask = cgr_pkg::WMASK_FULL;
            cgr_pkg::IDX_BLK_LEN: wr_mask = cgr_pkg::WMASK_BLKLEN;
            cgr_pkg::IDX_WD_CTRL: wr_mask = cgr_pkg::WMASK_WD;
            default:              wr_mask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] rst_val(input logic [7:0] idx);
        case (idx)
            cgr_pkg::IDX_USB_EN:  rst_val = cgr_pkg::RST_USB_EN;
            cgr_pkg::IDX_LINK_EN: rst_val = cgr_pkg::RST_LINK_EN;
            cgr_pkg::IDX_HOST_EN: rst_val = cgr_pkg::RST_HOST_EN;
            cgr_pkg::IDX_SWING_A: rst_val = cgr_pkg::RST_SWING_A;
            cgr_pkg::IDX_BLK_LEN: rst_val = cgr_pkg::RST_BLK_LEN;
            cgr_pkg::IDX_WD_CTRL: rst_val = cgr_pkg::RST_WD_CTRL;
            cgr_pkg::IDX_SWING_B: rst_val = cgr_pkg::RST_SWING_B;
            default:              rst_val = 8'h00;
        endcase
    endfunction

    // ---------------- link domain ----------------
    logic          lk_rst_s1_r;
    logic          lk_rst_s2_r;
    logic    [7:0] strap_s1_r;
    logic    [7:0] strap_s2_r;
    logic          alarm_s1_r;
    logic          alarm_s2_r;
    cgr_lk_state_t state_r;
    cgr_lk_state_t state_nxt;
    logic    [7:0] idx_r;
    logic          first_r;
    logic    [7:0] tx_byte_r;
    logic          wd_tgl_r;
    logic    [7:0] regs_r [0:cgr_pkg::NUM_REGS-1];

    wire lk_rst_n   = lk_rst_s2_r;
    wire addr_wr    = lk_rx_byte_i == cgr_pkg::ADDR_WR;
    wire addr_rd    = lk_rx_byte_i == cgr_pkg::ADDR_RD;
    wire in_range   = idx_r < 8'(cgr_pkg::NUM_REGS);
    wire [3:0] ridx = idx_r[3:0];
    wire wr_en      = (state_r == CGR_WDATA) && lk_rx_valid_i;
    wire [7:0] mask = wr_mask(idx_r);
    wire [7:0] cur  = in_range ? regs_r[ridx] : 8'h00;
    wire wd_wr      = wr_en && (idx_r == cgr_pkg::IDX_WD_CTRL);
    wire tx_take    = (state_r == CGR_RDATA) && lk_tx_req_i;

    // read value: byte 7 is a constant, byte 9 bit 6 reports the alarm
    wire [7:0] rd_wd  = {cur[7], alarm_s2_r, cur[5:0]};
    wire [7:0] rd_val = (idx_r == cgr_pkg::IDX_REV)     ? REV_MAKER :
                        (idx_r == cgr_pkg::IDX_WD_CTRL) ? rd_wd     : cur;

    assign lk_ack_o = lk_rx_valid_i && (
                      ((state_r == CGR_ADDR) && (addr_wr || addr_rd)) ||
                      (state_r == CGR_INDEX) || (state_r == CGR_COUNT) ||
                      (state_r == CGR_WDATA));

    always_comb begin
        state_nxt = state_r;
        if (lk_stop_i) begin
            state_nxt = CGR_IDLE;
        end else if (lk_start_i) begin
            state_nxt = CGR_ADDR;
        end else if (lk_rx_valid_i) begin
            case (state_r)
                CGR_ADDR:  state_nxt = addr_wr ? CGR_INDEX :
                                       addr_rd ? CGR_RDATA : CGR_IGNORE;
                CGR_INDEX: state_nxt = CGR_COUNT;
                CGR_COUNT: state_nxt = CGR_WDATA;
                CGR_WDATA: state_nxt = CGR_WDATA;
                default:   state_nxt = state_r;
            endcase
        end
    end

    // strap pins are resampled while reset holds, so the divider takes the settled value
    always_ff @(posedge link_clk_i) begin
        lk_rst_s1_r <= rst_n_i;
        lk_rst_s2_r <= lk_rst_s1_r;
        strap_s1_r  <= vco_strap_i;
        strap_s2_r  <= strap_s1_r;
        alarm_s1_r  <= hard_alarm_flag_o;
        alarm_s2_r  <= alarm_s1_r;
    end

    always_ff @(posedge link_clk_i) begin
        if (!lk_rst_n) begin
            state_r   <= CGR_IDLE;
            idx_r     <= 8'h00;
            first_r   <= 1'b0;
            tx_byte_r <= cgr_pkg::TX_IDLE;
        end else begin
            state_r <= state_nxt;
            if (state_r == CGR_INDEX && lk_rx_valid_i) begin
                idx_r <= lk_rx_byte_i;
            end else if (wr_en || (tx_take && !first_r)) begin
                idx_r <= idx_r + 8'h01;
            end
            if (state_r == CGR_ADDR && lk_rx_valid_i && addr_rd) begin
                first_r <= 1'b1;
            end else if (tx_take) begin
                first_r <= 1'b0;
            end
            if (tx_take) begin
                tx_byte_r <= first_r ? regs_r[cgr_pkg::IDX_BLK_LEN[3:0]] : rd_val;
            end else if (lk_tx_req_i) begin
                tx_byte_r <= cgr_pkg::TX_IDLE;
            end
        end
    end

    // only masked bits take host data; reserved bytes and read-only bits stay put
    always_ff @(posedge link_clk_i) begin
        if (!lk_rst_n) begin
            for (int i = 0; i < cgr_pkg::NUM_REGS; i++) begin
                regs_r[i] <= rst_val(8'(i));
            end
            regs_r[cgr_pkg::IDX_VCO_DIV[3:0]] <= strap_s2_r;
            wd_tgl_r <= 1'b0;
        end else begin
            if (wr_en && in_range) begin
                regs_r[ridx] <= (cur & ~mask) | (lk_rx_byte_i & mask);
            end
            if (wd_wr) begin
                wd_tgl_r <= ~wd_tgl_r;
            end
        end
    end

    assign lk_tx_byte_o                 = tx_byte_r;
    assign usb_clock_out_en_o           = regs_r[2][cgr_pkg::BIT_USB_EN];
    assign expansion_clock_pair_en_o    = regs_r[3][cgr_pkg::BIT_EXP_EN];
    assign storage_link_clock_pair_en_o = regs_r[3][cgr_pkg::BIT_STOR_EN];
    assign ref_clock_out_en_o           = regs_r[4][cgr_pkg::BIT_REF_EN];
    assign processor_clock_pair_en_o    = regs_r[4][cgr_pkg::BIT_CPU_EN];
    assign processor_swing_select_o     = regs_r[6][cgr_pkg::POS_SWING_HI +: 2];
    assign display_96mhz_swing_select_o = regs_r[6][cgr_pkg::POS_SWING_LO +: 2];
    assign expansion_swing_select_o     = regs_r[10][cgr_pkg::POS_SWING_HI +: 2];
    assign storage_link_swing_select_o  = regs_r[10][cgr_pkg::POS_SWING_STG +: 2];
    assign vco_feedback_divider_o       = regs_r[12];

    // ---------------- reference domain: watchdog ----------------
    // the control byte crosses by toggle handshake; it must not be rewritten within
    // four reference cycles, which the byte rate of the link guarantees
    logic                         tgl_s1_r;
    logic                         tgl_s2_r;
    logic                         tgl_s3_r;
    logic                         wd_en_r;
    logic                         wd_tb_r;
    logic                   [3:0] wd_cnt_r;
    logic [cgr_pkg::WD_UNIT_W-1:0] unit_r;
    logic                   [3:0] elapsed_r;
    logic                         alarm_r;

    wire cfg_ld = tgl_s2_r ^ tgl_s3_r;
    wire [7:0] wd_byte = regs_r[cgr_pkg::IDX_WD_CTRL[3:0]];
    wire [cgr_pkg::WD_UNIT_W-1:0] unit_lim = wd_tb_r ?
        cgr_pkg::WD_UNIT_W'(WD_LONG_CYC - 1) : cgr_pkg::WD_UNIT_W'(WD_SHORT_CYC - 1);
    wire unit_tick = unit_r == unit_lim;
    wire expired   = elapsed_r >= wd_cnt_r;
    wire alarm_nxt = wd_en_r && !cfg_ld && (alarm_r || expired);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_s3_r <= 1'b0;
            wd_en_r  <= 1'b0;
            wd_tb_r  <= 1'b0;
            wd_cnt_r <= cgr_pkg::RST_WD_CNT;
        end else begin
            tgl_s1_r <= wd_tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
            if (cfg_ld) begin
                wd_en_r  <= wd_byte[cgr_pkg::BIT_WD_EN];
                wd_tb_r  <= wd_byte[cgr_pkg::BIT_WD_TB];
                wd_cnt_r <= wd_byte[cgr_pkg::POS_WD_CNT +: 4];
            end
        end
    end

    // a write to the control byte restarts the count, which doubles as a kick
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || cfg_ld || !wd_en_r) begin
            unit_r    <= '0;
            elapsed_r <= 4'h0;
            alarm_r   <= 1'b0;
        end else begin
            alarm_r <= alarm_nxt;
            if (!expired) begin
                unit_r <= unit_tick ? '0 : unit_r + 1'b1;
                if (unit_tick) begin
                    elapsed_r <= elapsed_r + 4'h1;
                end
            end
        end
    end

    assign hard_alarm_flag_o = alarm_r;

    // ---------------- checks ----------------
    // the link reset synchroniser is unknown at power-on, so link checks also wait on rst_n_i
    wire lk_off = !rst_n_i || !lk_rst_n;

    chk_usb_en_write: assert property (@(posedge link_clk_i) disable iff (lk_off)
        wr_en && idx_r == cgr_pkg::IDX_USB_EN |=> usb_clock_out_en_o == $past(lk_rx_byte_i[7]))
        else $error("usb enable did not follow write");
    chk_link_en_write: assert property (@(posedge link_clk_i) disable iff (lk_off)
        wr_en && idx_r == cgr_pkg::IDX_LINK_EN
        |=> expansion_clock_pair_en_o == $past(lk_rx_byte_i[5])
            && storage_link_clock_pair_en_o == $past(lk_rx_byte_i[1]))
        else $error("link pair enables did not follow write");
    chk_host_en_write: assert property (@(posedge link_clk_i) disable iff (lk_off)
        wr_en && idx_r == cgr_pkg::IDX_HOST_EN
        |=> ref_clock_out_en_o == $past(lk_rx_byte_i[6])
            && processor_clock_pair_en_o == $past(lk_rx_byte_i[4]))
        else $error("host enables did not follow write");
    chk_cpu_swing_write: assert property (@(posedge link_clk_i) disable iff (lk_off)
        wr_en && idx_r == cgr_pkg::IDX_SWING_A
        |=> processor_swing_select_o == $past(lk_rx_byte_i[7:6]))
        else $error("processor swing did not follow write");
    chk_dot_swing_write: assert property (@(posedge link_clk_i) disable iff (lk_off)
        wr_en && idx_r == cgr_pkg::IDX_SWING_A
        |=> display_96mhz_swing_select_o == $past(lk_rx_byte_i[3:2]))
        else $error("display swing did not follow write");
    chk_exp_swing_write: assert property (@(posedge link_clk_i) disable iff (lk_off)
        wr_en && idx_r == cgr_pkg::IDX_SWING_B
        |=> expansion_swing_select_o == $past(lk_rx_byte_i[7:6]))
        else $error("expansion swing did not follow write");
    chk_stor_swing_write: assert property (@(posedge link_clk_i) disable iff (lk_off)
        wr_en && idx_r == cgr_pkg::IDX_SWING_B
        |=> storage_link_swing_select_o == $past(lk_rx_byte_i[5:4]))
        else $error("storage swing did not follow write");
    chk_divider_write: assert property (@(posedge link_clk_i) disable iff (lk_off)
        wr_en && idx_r == cgr_pkg::IDX_VCO_DIV |=> vco_feedback_divider_o == $past(lk_rx_byte_i))
        else $error("divider did not follow write");
    chk_rev_read_const: assert property (@(posedge link_clk_i) disable iff (lk_off)
        tx_take && !first_r && idx_r == cgr_pkg::IDX_REV |=> lk_tx_byte_o == REV_MAKER)
        else $error("revision byte read wrong");
    chk_count_ro_bits: assert property (@(posedge link_clk_i) disable iff (lk_off)
        regs_r[8][7:5] == 3'b000)
        else $error("byte count upper bits changed");
    chk_count_first: assert property (@(posedge link_clk_i) disable iff (lk_off)
        tx_take && first_r |=> lk_tx_byte_o == $past(regs_r[8]) && !first_r)
        else $error("block read did not start with count");
    chk_index_step: assert property (@(posedge link_clk_i) disable iff (lk_off)
        tx_take && !first_r |=> idx_r == $past(idx_r) + 8'h01)
        else $error("read index did not advance");
    chk_addr_nack: assert property (@(posedge link_clk_i) disable iff (lk_off)
        state_r == CGR_ADDR && lk_rx_valid_i && !lk_start_i && !lk_stop_i && !addr_wr && !addr_rd
        |-> !lk_ack_o ##1 state_r == CGR_IGNORE)
        else $error("foreign address answered");
    chk_reserved_quiet: assert property (@(posedge link_clk_i) disable iff (lk_off)
        regs_r[5] == 8'h00 && regs_r[11] == 8'h00)
        else $error("reserved byte changed");
    chk_alarm_armed: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        alarm_r |-> wd_en_r)
        else $error("alarm without enable");
    chk_alarm_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(alarm_r) |-> $past(wd_en_r && elapsed_r >= wd_cnt_r))
        else $error("alarm before count expired");
    chk_disarm_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !wd_en_r |=> !alarm_r)
        else $error("alarm stayed after disarm");
    chk_timebase_lim: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        unit_r <= unit_lim)
        else $error("unit counter passed timebase");
    chk_flag_reported: assert property (@(posedge link_clk_i) disable iff (lk_off)
        tx_take && !first_r && idx_r == cgr_pkg::IDX_WD_CTRL
        |=> lk_tx_byte_o[6] == $past(alarm_s2_r))
        else $error("alarm flag not reported");

    cov_block_write: cover property (@(posedge link_clk_i) disable iff (lk_off)
        wr_en ##1 wr_en);
    cov_block_read: cover property (@(posedge link_clk_i) disable iff (lk_off)
        tx_take && first_r ##[1:40] tx_take);
    cov_foreign_addr: cover property (@(posedge link_clk_i) disable iff (lk_off)
        state_r == CGR_ADDR && lk_rx_valid_i && !addr_wr && !addr_rd);
    cov_alarm_hit: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(alarm_r));
    cov_alarm_disarm: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        alarm_r ##1 !wd_en_r);
endmodule
`default_nettype wire

//--- cgr_host_model.sv
// link-side host model: frames, byte writes and byte fetches
`timescale 1ns/1ps
`default_nettype none
module cgr_host_model (
    input  wire logic       link_clk_i,
    input  wire logic       lk_ack_i,
    input  wire logic [7:0] lk_tx_byte_i,
    output logic            lk_start_o,
    output logic            lk_stop_o,
    output logic            lk_rx_valid_o,
    output logic      [7:0] lk_rx_byte_o,
    output logic            lk_tx_req_o
);
    initial begin
        lk_start_o = 1'b0;
        lk_stop_o = 1'b0;
        lk_rx_valid_o = 1'b0;
        lk_rx_byte_o = 8'h00;
        lk_tx_req_o = 1'b0;
    end
    task automatic frame(input logic is_stop);
        @(posedge link_clk_i);
        if (is_stop) lk_stop_o <= 1'b1;
        else lk_start_o <= 1'b1;
        @(posedge link_clk_i);
        lk_stop_o <= 1'b0;
        lk_start_o <= 1'b0;
    endtask
    // bus shows the inverse once valid drops, so a stale byte never looks fresh
    task automatic put(input logic [7:0] b, inout logic [1:0] s);
        @(posedge link_clk_i);
        lk_rx_valid_o <= 1'b1;
        lk_rx_byte_o <= b;
        // ack is combinational, so read it mid-cycle while the byte still stands
        @(negedge link_clk_i);
        s = {s[1] | lk_ack_i, s[0] & lk_ack_i};
        @(posedge link_clk_i);
        lk_rx_valid_o <= 1'b0;
        lk_rx_byte_o <= ~b;
    endtask
    task automatic get(output logic [7:0] b);
        @(posedge link_clk_i);
        lk_tx_req_o <= 1'b1;
        @(posedge link_clk_i);
        lk_tx_req_o <= 1'b0;
        @(posedge link_clk_i);
        b = lk_tx_byte_i;
    endtask
    // acks returns {any acked, all acked}
    task automatic block_write(input logic [7:0] addr, input logic [7:0] idx,
                               input logic [7:0] d[$], output logic [1:0] acks);
        acks = 2'b01;
        frame(1'b0);
        put(addr, acks);
        put(idx, acks);
        put(8'(d.size()), acks);
        foreach (d[i]) put(d[i], acks);
        frame(1'b1);
    endtask
    task automatic block_read(input logic [7:0] idx, input int n,
                              output logic [7:0] q[$], output logic [1:0] acks);
        logic [7:0] b;
        acks = 2'b01;
        q = {};
        frame(1'b0);
        put(cgr_pkg::ADDR_WR, acks);
        put(idx, acks);
        frame(1'b0);
        put(cgr_pkg::ADDR_RD, acks);
        for (int i = 0; i <= n; i++) begin
            get(b);
            q.push_back(b);
        end
        frame(1'b1);
    endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the clock generator register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [3:0] REV = 4'h3;   // arbitrary
    localparam logic [3:0] MAKER = 4'h9; // arbitrary
    localparam int SHORT = 20;
    localparam int LONG = 80;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] strap = 8'h00;
    logic st, sp, rv, ack, tq, usb, rf, ex, sa, cpu, alarm;
    logic [7:0] rb, tb_byte, div;
    logic [1:0] psw, dsw, esw, ssw;
    logic [7:0] shadow [0:12];
    logic [7:0] d[$];
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    always #5 ref_clk = ~ref_clk;
    initial begin
        #1.7;
        forever #3 link_clk = ~link_clk;
    end
    cgr_regs #(.WD_SHORT_CYC(SHORT), .WD_LONG_CYC(LONG), .REV_CODE(REV),
               .MAKER_CODE(MAKER)) i_cgr_regs (
        .ref_clk_i(ref_clk), .rst_n_i(rst_n), .link_clk_i(link_clk),
        .lk_start_i(st), .lk_stop_i(sp), .lk_rx_valid_i(rv), .lk_rx_byte_i(rb),
        .lk_ack_o(ack), .lk_tx_req_i(tq), .lk_tx_byte_o(tb_byte), .vco_strap_i(strap),
        .usb_clock_out_en_o(usb), .ref_clock_out_en_o(rf),
        .expansion_clock_pair_en_o(ex), .storage_link_clock_pair_en_o(sa),
        .processor_clock_pair_en_o(cpu), .processor_swing_select_o(psw),
        .display_96mhz_swing_select_o(dsw), .expansion_swing_select_o(esw),
        .storage_link_swing_select_o(ssw), .vco_feedback_divider_o(div),
        .hard_alarm_flag_o(alarm));
    cgr_host_model i_cgr_host_model (
        .link_clk_i(link_clk), .lk_ack_i(ack), .lk_tx_byte_i(tb_byte), .lk_start_o(st),
        .lk_stop_o(sp), .lk_rx_valid_o(rv), .lk_rx_byte_o(rb), .lk_tx_req_o(tq));
    function automatic logic [7:0] wmask(input int i);
        case (i)
            2, 3, 4, 6, 10, 12: wmask = 8'hff;
            8: wmask = 8'h1f;
            9: wmask = 8'hbf;
            default: wmask = 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] exp_rd(input int i);
        exp_rd = (i <= 12) ? shadow[i] : 8'h00;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] addr, input logic [7:0] idx, input logic [7:0] q[$]);
        logic [1:0] acks;
        i_cgr_host_model.block_write(addr, idx, q, acks);
        chk(acks, (addr == cgr_pkg::ADDR_WR) ? 2'b11 : 2'b00);
        if (addr == cgr_pkg::ADDR_WR) foreach (q[i]) if (idx + i <= 12)
            shadow[idx+i] = (shadow[idx+i] & ~wmask(idx+i)) | (q[i] & wmask(idx+i));
    endtask
    task automatic rd(input logic [7:0] idx, input int n);
        logic [7:0] q[$];
        logic [1:0] acks;
        i_cgr_host_model.block_read(idx, n, q, acks);
        chk(acks, 2'b11);
        chk(q[0], shadow[8]);
        for (int i = 0; i < n; i++) chk(q[i+1], exp_rd(idx + i));
        chk({3'h0, usb, rf, ex, sa, cpu, psw, dsw, esw, ssw}, {3'h0, shadow[2][7],
            shadow[4][6], shadow[3][5], shadow[3][1], shadow[4][4], shadow[6][7:6],
            shadow[6][3:2], shadow[10][7:6], shadow[10][5:4]});
        chk(div, shadow[12]);
    endtask
    // lower bound allows one unit of slack for where the load lands inside a unit
    task automatic wd(input logic tsel, input logic [3:0] cnt);
        int unit, lo, hi, n;
        unit = tsel ? LONG : SHORT;
        lo = (cnt == 0) ? 0 : (cnt - 1) * unit;
        hi = (cnt + 1) * unit + 8;
        wr(cgr_pkg::ADDR_WR, 8'h09, '{{1'b1, 1'b0, tsel, cnt, 1'b0}});
        n = 0;
        while (alarm !== 1'b1 && n < hi + 8) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n >= lo && n <= hi, 1'b1);
        shadow[9][6] = 1'b1;
        rd(8'h09, 1);
        wr(cgr_pkg::ADDR_WR, 8'h09, '{{1'b0, 1'b0, tsel, cnt, 1'b0}});
        repeat (8) @(posedge ref_clk);
        chk(alarm, 1'b0);
        shadow[9][6] = 1'b0;
        rd(8'h09, 1);
        $display("test watchdog %0d %0d done", tsel, cnt);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(11));
        shadow = '{8'h00, 8'h00, 8'hf8, 8'hf3, 8'hf4, 8'h00, 8'h8a, {REV, MAKER},
                   8'h0f, 8'h1e, 8'ha0, 8'h00, 8'h00};
        @(posedge ref_clk);
        strap <= 8'($urandom);
        repeat (7) @(posedge ref_clk);
        rst_n <= 1'b1;
        shadow[12] = strap;
        strap <= ~strap; // divider must keep the strap seen during reset
        repeat (4) @(posedge ref_clk);
        rd(8'h02, 12);
        $display("test reset done");
        repeat (3) begin
            d = {};
            repeat (7) d.push_back(8'($urandom));
            wr(cgr_pkg::ADDR_WR, 8'h02, d);
            d = {};
            repeat (3) d.push_back(8'($urandom));
            wr(cgr_pkg::ADDR_WR, 8'h0a, d);
            rd(8'h02, 12);
        end
        $display("test random done");
        wr(cgr_pkg::ADDR_WR, 8'h07, '{8'hff, 8'hff});
        wr(cgr_pkg::ADDR_WR, 8'h0b, '{8'hff, 8'h5a, 8'hff});
        wr(cgr_pkg::ADDR_WR, 8'h02, '{8'h00, 8'h00, 8'h00});
        wr(8'hd4, 8'h02, '{8'hff, 8'hff, 8'hff});
        rd(8'h02, 12);
        $display("test corner done");
        wd(1'b0, 4'h3);
        wd(1'b1, 4'h2);
        wd(1'b0, 4'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
